// ===== logic/raid_fw_seq.sv
// Firmware-side sequencer driving the command registers over APB
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "raid_map.svh"
module raid_fw_seq (
  input wire logic pclk,
  input wire logic presetn,
  raid_apb_if.host bus,
  input wire logic req,
  input wire logic [2:0] req_cmd,
  input wire logic req_erase,
  input wire logic [63:0] req_addr,
  input wire logic [63:0] req_len,
  input wire logic [31:0] req_pat,
  input wire logic [15:0][31:0] req_sq,
  output logic ready,
  output logic done,
  output logic fail,
  output logic verify_err,
  output logic [1:0][15:0] link_info,
  output logic off
);
  typedef struct packed {
    raid_pkg::host_state_t st;
    logic [1:0] ph;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [5:0] idx;
    logic [2:0] cmd;
    logic erase;
    logic [63:0] addr;
    logic [63:0] len;
    logic [31:0] pat;
    logic [15:0][31:0] sq;
    logic [1:0][15:0] link;
    logic ready;
    logic done;
    logic fail;
    logic vfail;
    logic off;
  } host_regs_t;

  host_regs_t q;
  host_regs_t n;
  logic need;
  logic wr;
  logic [11:0] a;
  logic [31:0] d;
  logic fin;
  logic [31:0] r;
  logic [11:0] widx;

  always_comb begin
    n = q;
    n.done = 1'b0;
    widx = {4'h0, q.idx, 2'b00};
    need = 1'b1;
    wr = 1'b0;
    a = `R_STS;
    d = 32'h0000_0000;
    case (q.st)
      raid_pkg::H_LINK: a = `R_LINK0 + widx; // [RULE1]
      raid_pkg::H_LSHOW: a = `R_LINK0 + widx;
      raid_pkg::H_PARAM: begin // [RULE16]
        wr = 1'b1;
        a = `R_ADR_L + widx;
        case (q.idx[2:0])
          3'h0: d = q.addr[31:0];
          3'h1: d = q.addr[63:32];
          3'h2: d = q.len[31:0];
          3'h3: d = q.len[63:32];
          default: d = q.pat;
        endcase
      end
      raid_pkg::H_SQ: begin
        wr = 1'b1;
        a = {`PAGE_SQ, 8'h00} + widx;
        d = q.sq[q.idx[3:0]]; // [RULE19]
      end
      raid_pkg::H_TMO: begin
        wr = 1'b1;
        a = `R_TMO; // [RULE8]
      end
      raid_pkg::H_CMD: begin
        wr = 1'b1;
        a = `R_CMD;
        d = {29'h0, q.cmd};
      end
      raid_pkg::H_CAP: a = `R_CAP_H;
      raid_pkg::H_REST: begin
        wr = 1'b1;
        a = `R_TMO;
        d = `TMO_DEF; // [RULE22]
      end
      raid_pkg::H_BOOT: a = `R_STS;
      raid_pkg::H_POLL: a = `R_STS;
      default: need = 1'b0;
    endcase
    fin = 1'b0;
    r = bus.prdata;
    case (q.ph)
      2'h0: begin
        if (need) begin
          n.psel = 1'b1;
          n.pwrite = wr;
          n.paddr = a;
          n.pwdata = d;
          n.ph = 2'h1;
        end
      end
      2'h1: begin
        n.penable = 1'b1;
        n.ph = 2'h2;
      end
      default: begin
        if (bus.pready) begin
          n.psel = 1'b0;
          n.penable = 1'b0;
          n.ph = 2'h0;
          fin = 1'b1;
        end
      end
    endcase
    case (q.st)
      raid_pkg::H_LINK: begin
        if (fin && r[`LINK_UP]) begin // [RULE1]
          n.idx = q.idx + 6'h1;
          if (q.idx[0]) begin
            n.st = raid_pkg::H_BOOT;
            n.idx = 6'h0;
          end
        end
      end
      raid_pkg::H_BOOT: begin
        if (fin && r[`STS_ERR]) begin
          n.st = raid_pkg::H_HALT; // [RULE2]
          n.fail = 1'b1;
        end else if (fin && !r[`STS_BUSY]) begin
          n.st = raid_pkg::H_LSHOW;
        end
      end
      raid_pkg::H_LSHOW: begin
        if (fin) begin
          n.link[q.idx[0]] = r[17:2]; // [RULE3]
          n.idx = q.idx + 6'h1;
          if (q.idx[0]) begin
            n.st = raid_pkg::H_IDLE;
            n.idx = 6'h0;
            n.ready = 1'b1;
          end
        end
      end
      raid_pkg::H_IDLE: begin
        if (req) begin
          n.ready = 1'b0;
          n.cmd = req_cmd;
          n.erase = req_erase && req_cmd == `CMD_ADMIN;
          n.addr = req_addr;
          n.len = req_len;
          n.pat = req_pat;
          n.sq = req_sq;
          n.vfail = 1'b0;
          n.idx = 6'h0;
          if (req_cmd == `CMD_WRITE || req_cmd == `CMD_READ) begin
            n.st = raid_pkg::H_PARAM;
          end else if (req_cmd == `CMD_ADMIN || req_cmd == `CMD_IO) begin
            n.st = raid_pkg::H_SQ;
          end else begin
            n.st = raid_pkg::H_CMD;
          end
        end
      end
      raid_pkg::H_PARAM: begin
        if (fin) begin
          n.idx = q.idx + 6'h1;
          if (q.idx == 6'h4) begin
            n.st = raid_pkg::H_CMD;
          end
        end
      end
      raid_pkg::H_SQ: begin
        if (fin) begin
          n.idx = q.idx + 6'h1;
          if (q.idx == 6'h1F) begin
            n.st = q.erase ? raid_pkg::H_TMO : raid_pkg::H_CMD;
          end
        end
      end
      raid_pkg::H_TMO: if (fin) n.st = raid_pkg::H_CMD;
      raid_pkg::H_CMD: if (fin) n.st = raid_pkg::H_POLL;
      raid_pkg::H_POLL: begin
        if (fin) begin
          if (r[`STS_VFAIL] && q.cmd == `CMD_READ) begin
            n.vfail = 1'b1; // [RULE17]
          end
          if (r[`STS_ERR]) begin
            n.st = raid_pkg::H_HALT; // [RULE11]
            n.fail = 1'b1;
          end else if (!r[`STS_BUSY]) begin
            if (q.cmd == `CMD_IDENT) begin
              n.st = raid_pkg::H_CAP;
            end else if (q.erase) begin
              n.st = raid_pkg::H_REST;
            end else if (q.cmd == `CMD_SHUT) begin
              n.st = raid_pkg::H_OFF; // [RULE23]
              n.off = 1'b1;
              n.done = 1'b1;
            end else begin
              n.st = raid_pkg::H_IDLE;
              n.ready = 1'b1;
              n.done = 1'b1;
            end
          end
        end
      end
      raid_pkg::H_CAP: begin
        if (fin && r[`CAP_MODE]) begin
          n.st = raid_pkg::H_HALT; // [RULE15]
          n.fail = 1'b1;
        end else if (fin) begin
          n.st = raid_pkg::H_IDLE;
          n.ready = 1'b1;
          n.done = 1'b1;
        end
      end
      raid_pkg::H_REST: begin
        if (fin) begin
          n.st = raid_pkg::H_IDLE;
          n.ready = 1'b1;
          n.done = 1'b1;
        end
      end
      default: n.ready = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= raid_pkg::H_LINK;
    end else begin
      q <= n;
    end
  end

  assign bus.psel = q.psel;
  assign bus.penable = q.penable;
  assign bus.pwrite = q.pwrite;
  assign bus.paddr = q.paddr;
  assign bus.pwdata = q.pwdata;
  assign ready = q.ready;
  assign done = q.done;
  assign fail = q.fail;
  assign verify_err = q.vfail;
  assign link_info = q.link;
  assign off = q.off;
endmodule

// ===== common/raid_map.svh
// Register offsets, field positions and reset values of the command block
// How it works
// RULE1: Host waits for link bit 0 high
// RULE2: Busy high during init; host halts on error
// RULE3: Link word bits 17..2 hold width/speed
// RULE4: Command 000b starts Identify on both drives
// RULE5: 010b starts Write, 011b starts Read
// RULE6: 100b launches custom admin command, SMART
// RULE7: 110b launches custom I/O command, Flush
// RULE8: Secure Erase loads entry, then 100b
// RULE9: Busy rises on accept, holds until both finish
// RULE10: Busy clears on successful completion
// RULE11: Status bit 1 flags error; host stops
// RULE12: One 32-bit error type word per channel
// RULE13: Identify data stored in identify buffer
// RULE14: Capacity two words, upper bit 31 mode
// RULE15: Host halts on 4 Kbyte block mode
// RULE16: Host loads address, length, pattern first
// RULE17: Read mismatch sets bit 2, keeps running
// RULE18: Two-word byte counter readable any time
// RULE19: Host writes all 16 entry dwords per channel
// RULE20: SMART log stored in custom data memory
// RULE21: Timeout value zero disables timeout timer
// RULE22: Host restores default timeout after erase
// RULE23: 001b Shutdown; afterwards no further commands
// RULE24: Command writes ignored while busy
`ifndef RAID_MAP_SVH
`define RAID_MAP_SVH
`define R_CMD 12'h000
`define R_STS 12'h004
`define R_ADR_L 12'h008
`define R_ADR_H 12'h00C
`define R_LEN_L 12'h010
`define R_LEN_H 12'h014
`define R_PAT 12'h018
`define R_TMO 12'h01C
`define R_CAP_L 12'h020
`define R_CAP_H 12'h024
`define R_CNT_L 12'h028
`define R_CNT_H 12'h02C
`define R_LINK0 12'h030
`define R_LINK1 12'h034
`define R_ETYPE0 12'h038
`define R_ETYPE1 12'h03C
`define PAGE_SQ 4'h1
`define PAGE_ID 4'h2
`define PAGE_CD 4'h3
`define CMD_IDENT 3'h0
`define CMD_SHUT 3'h1
`define CMD_WRITE 3'h2
`define CMD_READ 3'h3
`define CMD_ADMIN 3'h4
`define CMD_IO 3'h6
`define STS_BUSY 0
`define STS_ERR 1
`define STS_VFAIL 2
`define LINK_UP 0
`define CAP_MODE 31
`define ET_TIMEOUT 32'h8000_0000
`define TMO_DEF 32'h0EE6_B280
`endif

// ===== common/raid_pkg.sv
// Shared state types of both ends
package raid_pkg;
  typedef enum logic [1:0] {
    D_INIT = 2'h0,
    D_IDLE = 2'h1,
    D_RUN = 2'h3,
    D_OFF = 2'h2
  } dev_state_t;
  typedef enum logic [3:0] {
    H_LINK = 4'h0,
    H_BOOT = 4'h1,
    H_LSHOW = 4'h3,
    H_IDLE = 4'h2,
    H_PARAM = 4'h6,
    H_SQ = 4'h7,
    H_TMO = 4'h5,
    H_CMD = 4'h4,
    H_POLL = 4'hC,
    H_CAP = 4'hD,
    H_REST = 4'hF,
    H_HALT = 4'hE,
    H_OFF = 4'hA
  } host_state_t;
endpackage

// ===== common/raid_apb_if.sv
// APB link between the firmware end and the command register end
`timescale 1ns/1ps
interface raid_apb_if;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  modport dev (input psel, penable, pwrite, paddr, pwdata, output prdata, pready, pslverr);
  modport host (output psel, penable, pwrite, paddr, pwdata, input prdata, pready, pslverr);
endinterface

// ===== logic/raid_cmd_regs.sv
// Command, status and data registers of the two-channel striping controller
`timescale 1ns/1ps
`include "raid_map.svh"
module raid_cmd_regs #(
  parameter int MW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  raid_apb_if.dev bus,
  input wire logic init_done,
  input wire logic [1:0][17:0] link_status,
  input wire logic [63:0] capacity,
  input wire logic [1:0] ch_done,
  input wire logic [1:0] ch_err,
  input wire logic [1:0][31:0] ch_err_code,
  input wire logic verify_fail,
  input wire logic bytes_valid,
  input wire logic [31:0] bytes_add,
  input wire logic mem_we,
  input wire logic mem_sel,
  input wire logic mem_ch,
  input wire logic [$clog2(MW)-1:0] mem_idx,
  input wire logic [31:0] mem_wdata,
  input wire logic sq_ch,
  input wire logic [3:0] sq_idx,
  output logic [31:0] sq_rdata,
  output logic op_start,
  output logic [2:0] op_cmd,
  output logic [63:0] op_addr,
  output logic [63:0] op_len,
  output logic [31:0] op_pat,
  output logic busy
);
  localparam int AW = $clog2(2 * MW);
  typedef struct packed {
    raid_pkg::dev_state_t st;
    logic busy;
    logic err;
    logic vfail;
    logic [2:0] cmd;
    logic [1:0] dmask;
    logic start;
    logic [63:0] addr;
    logic [63:0] len;
    logic [31:0] pat;
    logic [31:0] tmo;
    logic [31:0] tcnt;
    logic [63:0] bytes;
    logic [1:0][31:0] etype;
    logic [31:0][31:0] sq;
    logic [2*MW-1:0][31:0] idm;
    logic [2*MW-1:0][31:0] cdm;
    logic [31:0] sq_rd;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dev_regs_t;

  dev_regs_t q;
  dev_regs_t n;
  logic [31:0] rd;
  logic hit;
  logic acc;
  logic [3:0] page;
  logic [5:0] widx;
  logic in_mem;

  assign page = bus.paddr[11:8];
  assign widx = bus.paddr[7:2];
  assign in_mem = 32'(widx) < 2 * MW;

  always_comb begin
    n = q;
    n.start = 1'b0;
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (bus.paddr)
      `R_CMD: rd = {29'h0, q.cmd};
      `R_STS: rd = {29'h0, q.vfail, q.err, q.busy};
      `R_ADR_L: rd = q.addr[31:0];
      `R_ADR_H: rd = q.addr[63:32];
      `R_LEN_L: rd = q.len[31:0];
      `R_LEN_H: rd = q.len[63:32];
      `R_PAT: rd = q.pat;
      `R_TMO: rd = q.tmo;
      `R_CAP_L: rd = capacity[31:0];
      `R_CAP_H: rd = capacity[63:32]; // [RULE14]
      `R_CNT_L: rd = q.bytes[31:0]; // [RULE18]
      `R_CNT_H: rd = q.bytes[63:32];
      `R_LINK0: rd = {14'h0, link_status[0]}; // [RULE3]
      `R_LINK1: rd = {14'h0, link_status[1]};
      `R_ETYPE0: rd = q.etype[0]; // [RULE12]
      `R_ETYPE1: rd = q.etype[1];
      default: begin
        if (page == `PAGE_SQ && !bus.paddr[7]) begin
          rd = q.sq[widx[4:0]];
        end else if (page == `PAGE_ID && in_mem) begin
          rd = q.idm[widx[AW-1:0]]; // [RULE13]
        end else if (page == `PAGE_CD && in_mem) begin
          rd = q.cdm[widx[AW-1:0]]; // [RULE20]
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    // Zero-wait slave: answer in the access cycle
    n.pready = bus.psel & ~bus.penable;
    n.pslverr = bus.psel & ~bus.penable & ~hit;
    if (bus.psel && !bus.penable) begin
      n.prdata = hit ? rd : 32'h0000_0000;
    end
    acc = bus.psel & bus.penable & q.pready & bus.pwrite & hit;
    if (acc) begin
      case (bus.paddr)
        `R_CMD: begin
          if (q.st == raid_pkg::D_IDLE) begin // [RULE24] [RULE23]
            n.st = raid_pkg::D_RUN;
            n.busy = 1'b1; // [RULE9]
            n.err = 1'b0;
            n.vfail = 1'b0;
            n.cmd = bus.pwdata[2:0]; // [RULE4] [RULE5] [RULE6] [RULE7]
            n.dmask = 2'b00;
            n.tcnt = 32'h0000_0000;
            n.etype = '0;
            n.start = 1'b1;
            if (bus.pwdata[2:0] == `CMD_WRITE || bus.pwdata[2:0] == `CMD_READ) begin
              n.bytes = 64'h0;
            end
          end
        end
        `R_ADR_L: n.addr[31:0] = bus.pwdata;
        `R_ADR_H: n.addr[63:32] = bus.pwdata;
        `R_LEN_L: n.len[31:0] = bus.pwdata;
        `R_LEN_H: n.len[63:32] = bus.pwdata;
        `R_PAT: n.pat = bus.pwdata;
        `R_TMO: n.tmo = bus.pwdata;
        default: begin
          if (page == `PAGE_SQ && !bus.paddr[7]) begin
            n.sq[widx[4:0]] = bus.pwdata;
          end else if (page == `PAGE_CD && in_mem) begin
            n.cdm[widx[AW-1:0]] = bus.pwdata;
          end
        end
      endcase
    end
    // Drive-side events come after the bus so a set beats a clear
    if (mem_we) begin
      if (mem_sel) begin
        n.cdm[{mem_ch, mem_idx}] = mem_wdata; // [RULE20]
      end else begin
        n.idm[{mem_ch, mem_idx}] = mem_wdata; // [RULE13]
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (ch_err[c] && q.st != raid_pkg::D_OFF) begin
        n.err = 1'b1; // [RULE11]
        n.etype[c] = n.etype[c] | ch_err_code[c]; // [RULE12]
      end
    end
    n.sq_rd = q.sq[{sq_ch, sq_idx}];
    case (q.st)
      raid_pkg::D_INIT: begin
        if (init_done) begin
          n.st = raid_pkg::D_IDLE;
          n.busy = 1'b0; // [RULE2]
        end
      end
      raid_pkg::D_RUN: begin
        n.dmask = q.dmask | ch_done;
        n.tcnt = q.tcnt + 32'h1;
        if (q.tmo != 32'h0 && q.tcnt >= q.tmo) begin // [RULE21]
          n.err = 1'b1;
          n.etype[0] = n.etype[0] | `ET_TIMEOUT;
        end
        if (verify_fail && q.cmd == `CMD_READ) begin
          n.vfail = 1'b1; // [RULE17]
        end
        if (bytes_valid && (q.cmd == `CMD_WRITE || q.cmd == `CMD_READ)) begin
          n.bytes = q.bytes + {32'h0, bytes_add}; // [RULE18]
        end
        if (n.err) begin
          n.st = raid_pkg::D_IDLE;
          n.busy = 1'b0;
        end else if (n.dmask == 2'b11) begin
          n.busy = 1'b0; // [RULE10]
          n.st = (q.cmd == `CMD_SHUT) ? raid_pkg::D_OFF : raid_pkg::D_IDLE; // [RULE23]
        end
      end
      raid_pkg::D_IDLE: n.busy = (n.st == raid_pkg::D_RUN); // [RULE9]
      default: n.busy = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= raid_pkg::D_INIT;
      q.busy <= 1'b1; // [RULE2]
      q.tmo <= `TMO_DEF;
    end else begin
      q <= n;
    end
  end

  assign bus.prdata = q.prdata;
  assign bus.pready = q.pready;
  assign bus.pslverr = q.pslverr;
  assign sq_rdata = q.sq_rd;
  assign op_start = q.start;
  assign op_cmd = q.cmd;
  assign op_addr = q.addr;
  assign op_len = q.len;
  assign op_pat = q.pat;
  assign busy = q.busy;
endmodule

// ===== sim/raid_apb_assertions.sv
// Concurrent checks on the APB link between the two ends
`timescale 1ns/1ps
`include "raid_map.svh"
module raid_apb_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite && !pslverr;
  wire logic wr = pready && pwrite;
  logic cmd_q;
  // Command written, no status read since
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 1'b0;
    end else if (wr && paddr == `R_CMD) begin
      cmd_q <= 1'b1;
    end else if (pready && paddr == `R_STS) begin
      cmd_q <= 1'b0;
    end
  end
  setup_answer_a: assert property (psel && !penable |=> penable && pready)
    else $error("no answer after setup");
  setup_hold_a: assert property (psel && !penable |=> psel && $stable(paddr)
    && $stable(pwdata) && $stable(pwrite)) else $error("request changed");
  answer_gap_a: assert property (pready |=> !pready && !psel)
    else $error("no idle after answer");
  mapped_ok_a: assert property (pready && paddr < 12'h040 |-> !pslverr)
    else $error("error on mapped word");
  busy_after_cmd_a: assert property (rd && paddr == `R_STS && cmd_q
    |-> prdata[`STS_BUSY]) else $error("busy not set after command");
  status_bits_a: assert property (rd && paddr == `R_STS |-> prdata[31:3] == 29'h0)
    else $error("status spare bits set");
  link_bits_a: assert property (rd && paddr[11:3] == 9'h006 |-> prdata[31:18] == 14'h0)
    else $error("link word spare bits set");
  cmd_code_a: assert property (wr && paddr == `R_CMD |-> pwdata[2:0] != 3'h5
    && pwdata[2:0] != 3'h7) else $error("bad command code");
  tmo_value_a: assert property (wr && paddr == `R_TMO
    |-> pwdata == 32'h0 || pwdata == `TMO_DEF) else $error("bad timeout value");
  word_align_a: assert property (psel |-> paddr[1:0] == 2'h0)
    else $error("unaligned address");
endmodule

// ===== sim/raid0_user_command_status_interface_tb.sv
// Self-checking bench joining the firmware end and the register end
`timescale 1ns/1ps
`include "raid_map.svh"
module raid0_user_command_status_interface_tb;
  logic pclk = 1'b0;
  logic presetn, init_done, verify_fail, bytes_valid, mem_we, mem_sel, mem_ch, sq_ch;
  logic req, req_erase, op_start, busy, ready, done, fail, verify_err, off, saw_done;
  logic [1:0][17:0] link_status;
  logic [63:0] capacity, req_addr, req_len, op_addr, op_len;
  logic [1:0] ch_done, ch_err;
  logic [1:0][31:0] ch_err_code;
  logic [31:0] bytes_add, mem_wdata, req_pat, op_pat, sq_rdata;
  logic [3:0] mem_idx, sq_idx;
  logic [2:0] req_cmd, op_cmd;
  logic [15:0][31:0] req_sq;
  logic [1:0][15:0] link_info;
  int failures = 0;
  int checked = 0;
  raid_apb_if bus_if ();
  raid_cmd_regs u_raid_cmd_regs (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .init_done(init_done), .link_status(link_status), .capacity(capacity),
    .ch_done(ch_done), .ch_err(ch_err), .ch_err_code(ch_err_code),
    .verify_fail(verify_fail), .bytes_valid(bytes_valid), .bytes_add(bytes_add),
    .mem_we(mem_we), .mem_sel(mem_sel), .mem_ch(mem_ch), .mem_idx(mem_idx),
    .mem_wdata(mem_wdata), .sq_ch(sq_ch), .sq_idx(sq_idx), .sq_rdata(sq_rdata),
    .op_start(op_start), .op_cmd(op_cmd), .op_addr(op_addr), .op_len(op_len),
    .op_pat(op_pat), .busy(busy));
  raid_fw_seq u_raid_fw_seq (.pclk(pclk), .presetn(presetn), .bus(bus_if), .req(req),
    .req_cmd(req_cmd), .req_erase(req_erase), .req_addr(req_addr), .req_len(req_len),
    .req_pat(req_pat), .req_sq(req_sq), .ready(ready), .done(done), .fail(fail),
    .verify_err(verify_err), .link_info(link_info), .off(off));
  raid_apb_assertions u_raid_apb_assertions (.pclk(pclk), .presetn(presetn),
    .psel(bus_if.psel), .penable(bus_if.penable), .pwrite(bus_if.pwrite),
    .paddr(bus_if.paddr), .pwdata(bus_if.pwdata), .prdata(bus_if.prdata),
    .pready(bus_if.pready), .pslverr(bus_if.pslverr));
  always #4 pclk = ~pclk;
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Waits for ready (0), op_start (1) or finish (2)
  task automatic wait_on(input int sel);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 400) begin
      @(posedge pclk);
      n++;
      saw_done = (done === 1'b1);
      hit = (sel == 0) ? (ready === 1'b1) : (sel == 1) ? (op_start === 1'b1)
        : (saw_done || fail === 1'b1);
    end
    chk("wait", hit, 1'b1);
  endtask
  task automatic boot(input logic mode);
    presetn <= 1'b0;
    init_done <= 1'b0;
    link_status <= '0;
    capacity <= {mode, 63'h0000_0001_2345_6000};
    tick(8);
    presetn <= 1'b1;
    tick(20);
    chk("ready", ready, 1'b0);
    link_status <= {18'h2_0045, 18'h1_FF09};
    tick(20);
    chk("ready", ready, 1'b0);
    chk("busy", busy, 1'b1);
    init_done <= 1'b1;
    wait_on(0);
    chk("link0", link_info[0], 16'h7FC2);
    chk("link1", link_info[1], 16'h8011);
  endtask
  // One command; err makes channel 1 report an error
  task automatic run(input logic [2:0] cmd, input logic er, input logic err);
    logic exp_fail;
    logic [31:0] mem_seen;
    exp_fail = err | (cmd == 3'h0 && capacity[63]);
    wait_on(0);
    req_cmd <= cmd;
    req_erase <= er;
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    wait_on(1);
    chk("op_cmd", op_cmd, cmd);
    chk("busy", busy, 1'b1);
    if (er) chk("tmo", u_raid_cmd_regs.q.tmo, 32'h0);
    if (cmd[2:1] == 2'b01) begin
      chk("op_addr", op_addr, req_addr);
      chk("op_len", op_len, req_len);
      chk("op_pat", op_pat, req_pat);
    end
    ch_done <= 2'b01;
    verify_fail <= (cmd == 3'h3);
    bytes_valid <= 1'b1;
    mem_we <= 1'b1;
    {mem_sel, mem_ch, mem_idx} <= {cmd[2], cmd[0], 1'b0, cmd};
    {mem_wdata, bytes_add} <= {req_pat, req_len[31:0]};
    @(posedge pclk);
    {ch_done, verify_fail, bytes_valid, mem_we} <= '0;
    tick(8);
    chk("busy", busy, 1'b1);
    mem_seen = mem_sel ? u_raid_cmd_regs.q.cdm[{mem_ch, mem_idx}]
      : u_raid_cmd_regs.q.idm[{mem_ch, mem_idx}];
    chk("mem", mem_seen, req_pat);
    if (cmd[2:1] == 2'b01) chk("bytes", u_raid_cmd_regs.q.bytes, req_len[31:0]);
    ch_err <= {err, 1'b0};
    ch_done <= {!err, 1'b0};
    @(posedge pclk);
    {ch_done, ch_err} <= '0;
    wait_on(2);
    chk("fail", fail, exp_fail);
    chk("done", saw_done, !exp_fail);
    chk("busy", busy, 1'b0);
    if (!exp_fail && cmd[2:1] == 2'b01) chk("verify", verify_err, cmd[0]);
    if (err) chk("etype", u_raid_cmd_regs.q.etype[1], ch_err_code[1]);
    if (er) chk("tmo", u_raid_cmd_regs.q.tmo, `TMO_DEF);
  endtask
  initial begin
    {presetn, init_done, verify_fail, bytes_valid, mem_we, mem_sel, mem_ch, sq_ch} <= '0;
    {req, req_erase, link_status, ch_done, ch_err, mem_idx, sq_idx, req_cmd} <= '0;
    {mem_wdata, bytes_add} <= '0;
    ch_err_code <= {32'h0000_0100, 32'h0000_0040};
    req_addr <= 64'h0000_0002_0000_1000;
    req_len <= 64'h0000_0000_0004_0000;
    req_pat <= 32'h0000_0003;
    for (int i = 0; i < 16; i++) begin
      req_sq[i] <= {28'hC0D_E5A1, i[3:0]};
    end
    boot(1'b0);
    run(3'h0, 1'b0, 1'b0);
    run(3'h2, 1'b0, 1'b0);
    run(3'h3, 1'b0, 1'b0);
    run(3'h4, 1'b0, 1'b0);
    sq_ch <= 1'b1;
    sq_idx <= 4'hF;
    tick(3);
    chk("sq1", sq_rdata, req_sq[15]);
    sq_ch <= 1'b0;
    sq_idx <= 4'h3;
    tick(3);
    chk("sq0", sq_rdata, req_sq[3]);
    run(3'h6, 1'b0, 1'b0);
    run(3'h4, 1'b1, 1'b0);
    run(3'h1, 1'b0, 1'b0);
    tick(10);
    chk("off", off, 1'b1);
    chk("ready", ready, 1'b0);
    boot(1'b0);
    run(3'h3, 1'b0, 1'b1);
    boot(1'b1);
    run(3'h0, 1'b0, 1'b0);
    end_sim();
  end
  initial begin
    tick(30000);
    failures++;
    end_sim();
  end
endmodule
